// ==== hdl/lss_sequencer.sv ====
// Startup and fault sequencer for a four-channel boost LED driver
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Wait for supply lockout and enable high
// - Switch boost only after all safety checks
// - Enable low over 16 ms shuts down
// - Detection needs dimming high and gate ready
// - Wait 1.5 ms above 120 mV, then soft start
// - Classify pins: short, unused, active
// - Unused channels disabled and leave regulation
// - Shorted pin holds off soft start, auto-resume
// - Base variant flags short faults, keeps retrying
// - Fault release point depends on variant
// - Output below OUTPUT_UNDERVOLTAGE_FAULT level blocks soft start
// - Output undervoltage shuts down and latches
// - Supply drop or long enable-low clears latch
// - Long dimming-low clears latch, clock stays
// - Soft start ends at first of three
// - Fixed ramp over 8 or 16 ms
// - Enable starts regulator and clock; gate pull after checks pass
// - Clamp oscillator; shut down on freq-pin short
// - Held-low freq pin blocks power-up
// - Switching frequency between 260 kHz and 2.3 MHz
// - Boost and channels enabled only by dimming high
module lss_sequencer
  import lss_pkg::*;
#(
  parameter int unsigned EN_OFF_LIM = EN_OFF_CYC,
  parameter int unsigned CLEAR_LIM  = CLEAR_CYC,
  parameter int unsigned SS_BASE    = SS_BASE_CYC,
  parameter int unsigned SS_LONG    = SS_LONG_CYC,
  parameter bit          LONG_VAR   = 1'b0
)
(
  input  wire logic           sys_clk,
  input  wire logic           rst_b,
  input  wire logic           enable_in,
  input  wire logic           dim_in,
  input  wire lss_analog_s    analog,
  input  wire lss_led_sense_s led_sense,
  input  wire logic [NCH-1:0] ch_in_reg,
  output logic                regulator_on,
  output logic                clock_output_en,
  output logic                gate_pull_en,
  output logic                current_ref_en,
  output logic                boost_en,
  output logic                osc_clamp,
  output logic [NCH-1:0]      ch_enable,
  output logic [NCH-1:0]      ch_short,
  output logic [RAMP_W-1:0]   ramp_level,
  output logic                fault_n_o,
  output logic                fault_n_oe,
  output logic [3:0]          state_o
);

  // ==========================================================
  // State and timers
  // ==========================================================
  lss_state_e       state_q;
  lss_state_e       state_d;
  logic [NCH-1:0]   unused_q;
  logic [NCH-1:0]   short_q;
  logic             fault_q;
  logic [RAMP_W-1:0] ramp_q;
  logic             en_off_exp;
  logic             clr_exp;
  logic             det_exp;
  logic             ss_exp;
  logic [CNT_W-1:0] ss_cnt;
  logic [CNT_W-1:0] ss_lim;
  logic             checks_ok;
  logic             any_short;
  logic             freq_program_pin_block;
  logic             all_reg;
  logic             det_arm;

  assign ss_lim = LONG_VAR ? CNT_W'(SS_LONG) : CNT_W'(SS_BASE);
  assign any_short = |(~led_sense.above_120mv);
  // Held-low freq pin only passes once it floats up or sync appears
  assign freq_program_pin_block = analog.freq_program_pin_short && !(analog.freq_program_pin_at_1v || analog.sync_seen);
  assign checks_ok = !analog.out_short && !freq_program_pin_block && !analog.freq_program_pin_open &&
                     !analog.current_program_pin_short && !analog.current_program_pin_open;
  // Detection timer starts once every pin clears 120 mV
  assign det_arm = (state_q == ST_DETECT) && !any_short;
  assign all_reg = &(ch_in_reg | unused_q);

  lss_timer u_en_off (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .run     (!enable_in && (state_q != ST_OFF)),
    .limit   (CNT_W'(EN_OFF_LIM)),
    .expired (en_off_exp),
    .count   ()
  );

  lss_timer u_clear (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .run     (enable_in && !dim_in && (state_q == ST_LATCH)),
    .limit   (CNT_W'(CLEAR_LIM)),
    .expired (clr_exp),
    .count   ()
  );

  lss_timer u_detect (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .run     (det_arm),
    .limit   (CNT_W'(DETECT_CYC)),
    .expired (det_exp),
    .count   ()
  );

  lss_timer u_soft (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .run     (state_q == ST_SOFT),
    .limit   (ss_lim),
    .expired (ss_exp),
    .count   (ss_cnt)
  );

  // ==========================================================
  // Sequence
  // ==========================================================
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_OFF:
        if (analog.vin_uvlo_ok && enable_in)
          state_d = ST_CHECK;
      ST_CHECK:
        if (checks_ok)
          state_d = ST_GATE;
      ST_GATE:
        if (analog.gate_at_3v3)
          state_d = ST_WAITDIM;
      ST_WAITDIM:
        if (dim_in && checks_ok)
          state_d = ST_DETECT;
      ST_DETECT:
        if (!analog.out_above_uvp && det_exp)
          state_d = ST_LATCH;
        else if (det_exp && checks_ok)
          state_d = ST_SOFT;
      ST_SOFT:
        if (!analog.out_above_uvp && ss_exp)
          state_d = ST_LATCH;
        else if (all_reg || analog.out_above_93pct || ss_exp)
          state_d = ST_RUN;
      ST_RUN:
        state_d = ST_RUN;
      ST_LATCH:
        if (clr_exp)
          state_d = ST_CHECK;
      default:
        state_d = ST_OFF;
    endcase
    // Supply loss or long enable-low override all; shorted freq pin without sync forces check except in off, check or latch
    if (!analog.vin_uvlo_ok || en_off_exp)
      state_d = ST_OFF;
    else if (analog.freq_program_pin_short && !analog.sync_seen && state_q != ST_OFF &&
             state_q != ST_CHECK && state_q != ST_LATCH)
      state_d = ST_CHECK;
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_q <= ST_OFF;
    else
      state_q <= state_d;
  end

  // ==========================================================
  // Channel classification
  // ==========================================================
  // Unused: above 120 mV yet below 340 mV (resistor-terminated pin)
  generate
    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
      always_ff @(posedge sys_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          unused_q[i] <= 1'b0;
          short_q[i]  <= 1'b0;
        end
        else if (state_q == ST_OFF || state_q == ST_WAITDIM)
        begin
          unused_q[i] <= 1'b0;
          short_q[i]  <= 1'b0;
        end
        else if (state_q == ST_DETECT)
        begin
          short_q[i] <= !led_sense.above_120mv[i];
          if (det_exp)
            unused_q[i] <= !led_sense.above_340mv[i];
        end
      end
    end
  endgenerate

  // ==========================================================
  // Fault output
  // ==========================================================
  // Long variant does not flag LED shorts; it only releases early
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      fault_q <= 1'b0;
    else if (state_q == ST_OFF || state_d == ST_OFF)
      fault_q <= 1'b0;
    else if (state_d == ST_LATCH || state_q == ST_LATCH)
      fault_q <= 1'b1;
    else if ((analog.freq_program_pin_short && !analog.sync_seen) || analog.current_program_pin_short)
      fault_q <= 1'b1;
    else if (!LONG_VAR && state_q == ST_DETECT && any_short)
      fault_q <= 1'b1;
    else if (!LONG_VAR && state_q == ST_DETECT && det_exp)
      fault_q <= 1'b0;
    else if (LONG_VAR && state_q == ST_WAITDIM && state_d == ST_DETECT)
      fault_q <= 1'b0;
    else if (state_q == ST_RUN || state_q == ST_SOFT)
      fault_q <= 1'b0;
  end

  // ==========================================================
  // Soft-start ramp
  // ==========================================================
  // Ramp target is a fraction of the overvoltage set point
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      ramp_q <= RAMP_RST;
    else if (state_q == ST_SOFT)
      ramp_q <= RAMP_W'((ss_cnt * 32'(2**RAMP_W - 1)) / ss_lim);
    else if (state_q == ST_RUN)
      ramp_q <= '1;
    else
      ramp_q <= RAMP_RST;
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign regulator_on    = (state_q != ST_OFF);
  assign clock_output_en = (state_q != ST_OFF);
  assign gate_pull_en    = (state_q != ST_OFF) && (state_q != ST_LATCH) &&
                           (state_q != ST_CHECK);
  assign current_ref_en  = (state_q == ST_WAITDIM) || (state_q == ST_DETECT) ||
                           (state_q == ST_SOFT) || (state_q == ST_RUN);
  assign boost_en        = ((state_q == ST_SOFT) || (state_q == ST_RUN)) &&
                           dim_in && enable_in;
  assign ch_enable       = boost_en ? ~unused_q : '0;
  assign ch_short        = short_q;
  assign ramp_level      = ramp_q;
  assign osc_clamp       = analog.freq_fault;
  assign fault_n_o       = 1'b0;
  assign fault_n_oe      = fault_q;
  assign state_o         = state_q;

  // ==========================================================
  // Checks
  // ==========================================================
  boost_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    boost_en |-> (state_q == ST_SOFT || state_q == ST_RUN) && dim_in)
    else $error("boost on outside soft start or run");

  start_cond_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_OFF && state_d == ST_CHECK) |-> analog.vin_uvlo_ok && enable_in)
    else $error("left off without supply and enable");

  detect_entry_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_WAITDIM) ##1 (state_q == ST_DETECT) |-> $past(dim_in))
    else $error("detection began without dimming high");

  enable_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    en_off_exp |=> state_q == ST_OFF)
    else $error("no shutdown after long enable low");

  short_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_DETECT && any_short) |=> state_q != ST_SOFT)
    else $error("soft start despite shorted pin");

  latch_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_LATCH && !clr_exp && analog.vin_uvlo_ok && !en_off_exp)
    |=> state_q == ST_LATCH)
    else $error("latched fault left early");

  latch_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_q == ST_LATCH |-> fault_n_oe)
    else $error("latched fault not flagged");

  soft_end_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_SOFT && ss_exp && analog.out_above_uvp && analog.vin_uvlo_ok
     && !en_off_exp && !(analog.freq_program_pin_short && !analog.sync_seen))
    |=> state_q == ST_RUN)
    else $error("soft start outlived its timer");

  unused_off_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (ch_enable & unused_q) == '0)
    else $error("unused channel enabled");

  clock_run_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_q == ST_LATCH |-> clock_output_en)
    else $error("clock stopped while latched");

  short_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!LONG_VAR && state_q == ST_DETECT && any_short && analog.vin_uvlo_ok && !en_off_exp)
    |=> fault_n_oe)
    else $error("shorted pin not flagged");

  fault_release_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (!LONG_VAR && state_q == ST_DETECT && det_exp && state_d == ST_SOFT &&
     !analog.freq_program_pin_short && !analog.current_program_pin_short) |=> !fault_n_oe)
    else $error("fault held past detection end");

  long_release_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (LONG_VAR && state_q == ST_WAITDIM && state_d == ST_DETECT &&
     !analog.freq_program_pin_short && !analog.current_program_pin_short) |=> !fault_n_oe)
    else $error("fault held past detection start");

  uvp_latch_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_q == ST_DETECT && det_exp && !analog.out_above_uvp && analog.vin_uvlo_ok &&
     !en_off_exp && !(analog.freq_program_pin_short && !analog.sync_seen)) |=> state_q == ST_LATCH)
    else $error("low output did not latch");

  supply_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !analog.vin_uvlo_ok |=> state_q == ST_OFF && !fault_n_oe)
    else $error("supply loss left fault or state active");

  ramp_full_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    state_q == ST_RUN |=> ramp_level == '1)
    else $error("ramp not at full scale in run");

endmodule : lss_sequencer
`default_nettype wire

// ==== shared/lss_pkg.sv ====
// Shared constants and types for the LED driver startup sequencer
package lss_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned DETECT_US       = 1500;   // LED short-check wait
  localparam int unsigned EN_OFF_MS       = 16;     // Enable-low shutdown
  localparam int unsigned CLEAR_MS        = 16;     // Dim-low fault clear
  localparam int unsigned SS_BASE_MS      = 8;
  localparam int unsigned SS_LONG_MS      = 16;
  localparam int unsigned DETECT_CYC      = DETECT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned EN_OFF_CYC      = EN_OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned CLEAR_CYC       = CLEAR_MS * (CLK_HZ / 1000);
  localparam int unsigned SS_BASE_CYC     = SS_BASE_MS * (CLK_HZ / 1000);
  localparam int unsigned SS_LONG_CYC     = SS_LONG_MS * (CLK_HZ / 1000);

  // Switching frequency limits, kHz; minimum sync pulse, ns
  localparam int unsigned FSW_MIN_KHZ     = 260;
  localparam int unsigned FSW_MAX_KHZ     = 2300;
  localparam int unsigned FOSC_CLAMP_KHZ  = 3500;
  localparam int unsigned SYNC_MIN_NS     = 150;

  // ==========================================================
  // Geometry
  // ==========================================================
  localparam int unsigned NCH             = 4;
  localparam int unsigned CNT_W           = 24;
  localparam int unsigned RAMP_W          = 8;
  localparam logic [RAMP_W-1:0] RAMP_RST  = 8'h00;

  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [3:0] {
    ST_OFF     = 4'b0000,
    ST_CHECK   = 4'b0001,
    ST_GATE    = 4'b0010,
    ST_WAITDIM = 4'b0011,
    ST_DETECT  = 4'b0100,
    ST_SOFT    = 4'b0101,
    ST_RUN     = 4'b0110,
    ST_LATCH   = 4'b0111
  } lss_state_e;

  // LED pin comparator levels, one bit per channel
  typedef struct packed {
    logic [NCH-1:0] above_120mv;
    logic [NCH-1:0] above_340mv;
  } lss_led_sense_s;

  // Analog status flags fed in from comparators
  typedef struct packed {
    logic vin_uvlo_ok;
    logic gate_at_3v3;
    logic freq_program_pin_short;
    logic freq_program_pin_open;
    logic current_program_pin_short;
    logic current_program_pin_open;
    logic sync_seen;
    logic freq_program_pin_at_1v;
    logic out_short;
    logic out_above_uvp;
    logic out_above_93pct;
    logic freq_fault;
  } lss_analog_s;

endpackage : lss_pkg

// ==== hdl/lss_timer.sv ====
// Saturating up-counter with a limit compare, used for every sequencer delay
`timescale 1ns/1ns
`default_nettype none
module lss_timer
  import lss_pkg::*;
(
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             run,
  input  wire logic [CNT_W-1:0] limit,
  output logic                  expired,
  output logic [CNT_W-1:0]      count
);

  logic [CNT_W-1:0] cnt_q;

  // Counts up to limit while run is high; clears on the next clock edge after run drops
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_q <= '0;
    else if (!run)
      cnt_q <= '0;
    else if (cnt_q < limit)
      cnt_q <= cnt_q + 1'b1;
  end

  assign expired = run && (cnt_q >= limit);
  assign count   = cnt_q;

endmodule : lss_timer
`default_nettype wire

// ==== verification/lss_host_model.sv ====
// Host-side model driving enable, dimming and external sync
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Host controller
// ==========================================================
module lss_host_model
(
  input  wire logic want_en,
  input  wire logic want_dim,
  input  wire logic tie_dim,
  input  wire logic sync_on,
  output logic      enable_in,
  output logic      dim_in,
  output logic      sync_seen,
  output logic      sync_clk
);
  // Tying dimming to enable gives one-wire power and brightness control
  assign enable_in = want_en;
  assign dim_in    = tie_dim ? want_en : want_dim;
  assign sync_seen = sync_on;
  // 250 ns phases give 2 MHz; the clock stands low while sync is off
  initial
  begin
    sync_clk = 1'b0;
    forever #250 sync_clk = sync_on ? ~sync_clk : 1'b0;
  end
endmodule : lss_host_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking testbench for the startup sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import lss_pkg::*;
;
  // ==========================================================
  // Signals
  // ==========================================================
  localparam int unsigned EN_LIM  = 60;
  localparam int unsigned CLR_LIM = 50;
  localparam int unsigned SS_B    = 40;
  logic           sys_clk, rst_b, want_en, want_dim, tie_dim, sync_on;
  logic           enable_in, dim_in, sync_seen, sync_clk, fault_pin;
  logic           regulator_on, clock_output_en, gate_pull_en, current_ref_en;
  logic           boost_en, osc_clamp, fault_n_o, fault_n_oe, fault_oe_l;
  logic [NCH-1:0] ch_in_reg, ch_enable, ch_short;
  logic [7:0]     ramp_level;
  logic [3:0]     state_o, state_l;
  lss_analog_s    an_q, analog;
  lss_led_sense_s led_sense;
  int             err_count = 0;
  int             n_tests   = 0;

  always_comb
  begin
    analog = an_q;
    analog.sync_seen = sync_seen;
  end
  // Open-drain fault line with an external pull-up
  assign fault_pin = fault_n_oe ? fault_n_o : 1'b1;

  lss_host_model u_host (.want_en(want_en), .want_dim(want_dim), .tie_dim(tie_dim),
    .sync_on(sync_on), .enable_in(enable_in), .dim_in(dim_in),
    .sync_seen(sync_seen), .sync_clk(sync_clk));

  lss_sequencer #(.EN_OFF_LIM(EN_LIM), .CLEAR_LIM(CLR_LIM), .SS_BASE(SS_B),
    .SS_LONG(80), .LONG_VAR(1'b0)) DUT (.sys_clk(sys_clk), .rst_b(rst_b),
    .enable_in(enable_in), .dim_in(dim_in), .analog(analog),
    .led_sense(led_sense), .ch_in_reg(ch_in_reg), .regulator_on(regulator_on),
    .clock_output_en(clock_output_en), .gate_pull_en(gate_pull_en),
    .current_ref_en(current_ref_en), .boost_en(boost_en), .osc_clamp(osc_clamp),
    .ch_enable(ch_enable), .ch_short(ch_short), .ramp_level(ramp_level),
    .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe), .state_o(state_o));

  // Long soft-start variant in lockstep, to see its own fault release and timer
  lss_sequencer #(.EN_OFF_LIM(EN_LIM), .CLEAR_LIM(CLR_LIM), .SS_BASE(SS_B),
    .SS_LONG(80), .LONG_VAR(1'b1)) DUT_L (.sys_clk(sys_clk), .rst_b(rst_b),
    .enable_in(enable_in), .dim_in(dim_in), .analog(analog),
    .led_sense(led_sense), .ch_in_reg(ch_in_reg), .regulator_on(),
    .clock_output_en(), .gate_pull_en(), .current_ref_en(), .boost_en(),
    .osc_clamp(), .ch_enable(), .ch_short(), .ramp_level(), .fault_n_o(),
    .fault_n_oe(fault_oe_l), .state_o(state_l));

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc

  // Bounded wait for a state code; n ends above lim if it never shows
  task automatic wait_st(input logic [3:0] s, input int lim, output int n);
    n = 0;
    while (state_o !== s && n <= lim)
    begin
      @(negedge sys_clk);
      n++;
    end
  endtask : wait_st

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_power_on();
    int n;
    chk(state_o, ST_OFF);
    chk(fault_pin, 1'b1);
    an_q.out_short = 1'b1;
    an_q.freq_program_pin_short = 1'b1;
    want_en = 1'b1;
    cyc(5);
    chk(state_o, ST_OFF);
    an_q.vin_uvlo_ok = 1'b1;
    cyc(1);
    chk(state_o, ST_CHECK);
    chk({regulator_on, clock_output_en, gate_pull_en}, 3'b110);
    cyc(10);
    chk(state_o, ST_CHECK);
    chk(fault_pin, 1'b0);
    an_q.out_short = 1'b0;
    cyc(10);
    chk(state_o, ST_CHECK);
    sync_on = 1'b1;
    wait_st(ST_GATE, 3, n);
    chk(state_o, ST_GATE);
    chk({gate_pull_en, current_ref_en}, 2'b10);
    an_q.freq_program_pin_short = 1'b0;
    an_q.freq_program_pin_at_1v = 1'b1;
    sync_on = 1'b0;
    an_q.gate_at_3v3 = 1'b1;
    wait_st(ST_WAITDIM, 3, n);
    chk(current_ref_en, 1'b1);
    cyc(20);
    chk({state_o, boost_en}, {ST_WAITDIM, 1'b0});
    chk(fault_oe_l, 1'b1);
    $display("test power_on done");
  endtask : t_power_on

  task automatic t_detect_run();
    int n;
    led_sense.above_120mv = 4'b1110;
    led_sense.above_340mv = 4'b1010;
    want_dim = 1'b1;
    wait_st(ST_DETECT, 3, n);
    chk(state_o, ST_DETECT);
    chk(fault_oe_l, 1'b0);
    cyc(15500);
    chk({state_o, fault_pin}, {ST_DETECT, 1'b0});
    chk(ch_short, 4'b0001);
    chk(fault_oe_l, 1'b0);
    led_sense.above_120mv = 4'hF;
    led_sense.above_340mv = 4'hB;
    cyc(100);
    chk(fault_pin, 1'b0);
    wait_st(ST_SOFT, 15100, n);
    chk(n >= 14898 && n <= 14902, 1'b1);
    chk(fault_pin, 1'b1);
    chk({boost_en, ch_enable}, 5'b11011);
    cyc(20);
    chk(ramp_level !== RAMP_RST && ramp_level !== 8'hFF, 1'b1);
    wait_st(ST_RUN, SS_B, n);
    chk(n + 20 >= SS_B - 2 && n + 20 <= SS_B + 2, 1'b1);
    chk(ramp_level, 8'hFF);
    chk(state_l, ST_SOFT);
    ch_in_reg = 4'b1011;
    cyc(1);
    chk(state_l, ST_RUN);
    ch_in_reg = '0;
    want_dim = 1'b0;
    cyc(1);
    chk({state_o, boost_en, ch_enable}, {ST_RUN, 5'b00000});
    want_dim = 1'b1;
    cyc(1);
    chk(boost_en, 1'b1);
    an_q.freq_fault = 1'b1;
    cyc(1);
    chk(osc_clamp, 1'b1);
    an_q.freq_fault = 1'b0;
    an_q.freq_program_pin_short = 1'b1;
    an_q.freq_program_pin_at_1v = 1'b0;
    wait_st(ST_CHECK, 3, n);
    chk({state_o, fault_pin}, {ST_CHECK, 1'b0});
    an_q.freq_program_pin_short = 1'b0;
    an_q.freq_program_pin_at_1v = 1'b1;
    $display("test detect_run done");
  endtask : t_detect_run

  task automatic t_en_off();
    int n;
    cyc(5);
    want_en = 1'b0;
    cyc(EN_LIM / 2);
    chk(state_o !== ST_OFF, 1'b1);
    want_en = 1'b1;
    cyc(2);
    want_en = 1'b0;
    wait_st(ST_OFF, EN_LIM + 3, n);
    chk(n >= EN_LIM - 2, 1'b1);
    chk({state_o, regulator_on}, {ST_OFF, 1'b0});
    $display("test en_off done");
  endtask : t_en_off

  task automatic t_uvp();
    int n;
    an_q.out_above_uvp = 1'b0;
    tie_dim = 1'b1;
    want_en = 1'b1;
    wait_st(ST_LATCH, 15100, n);
    chk({state_o, fault_pin, boost_en}, {ST_LATCH, 2'b00});
    tie_dim = 1'b0;
    want_dim = 1'b0;
    cyc(CLR_LIM / 2);
    chk(state_o, ST_LATCH);
    wait_st(ST_CHECK, CLR_LIM, n);
    chk(n + CLR_LIM / 2 >= CLR_LIM && n + CLR_LIM / 2 <= CLR_LIM + 2, 1'b1);
    chk({state_o, clock_output_en}, {ST_CHECK, 1'b1});
    want_dim = 1'b1;
    wait_st(ST_LATCH, 15100, n);
    chk(state_o, ST_LATCH);
    an_q.vin_uvlo_ok = 1'b0;
    wait_st(ST_OFF, 3, n);
    chk({state_o, fault_pin}, {ST_OFF, 1'b1});
    $display("test uvp done");
  endtask : t_uvp

  // ==========================================================
  // Clock, sequence and watchdog
  // ==========================================================
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial
  begin
    rst_b = 1'b0;
    want_en = 1'b0;
    want_dim = 1'b0;
    tie_dim = 1'b0;
    sync_on = 1'b0;
    an_q = '0;
    an_q.out_above_uvp = 1'b1;
    led_sense = '0;
    ch_in_reg = '0;
    cyc(12);
    rst_b = 1'b1;
    cyc(1);
    t_power_on();
    t_detect_run();
    t_en_off();
    t_uvp();
    print_verdict();
  end

  // About 61k cycles are expected; cut off at 90k
  initial
  begin
    #9_000_000;
    err_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
